// >>> design/fgroc_ctrl.v
// Host controller that drives a parallel NOR flash through its pins.
// Assumes a register master on the same clock and a flash with no clock of its own.
//
// Implementation choices: the register offsets and the address-and-strobe port.
`timescale 1ns/10ps
`include "fgroc_map.vh"
module fgroc_ctrl (
  input wire clock_in,
  input wire rst_in,
  input wire [7:0] reg_addr_in,
  input wire [31:0] reg_wdata_in,
  input wire reg_write_in,
  input wire reg_read_in,
  output reg [31:0] reg_rdata_out,
  output reg flash_ce_n_out,
  output reg flash_oe_n_out,
  output reg flash_we_n_out,
  output reg flash_reset_n_out,
  output reg [21:0] flash_addr_out,
  output reg [15:0] flash_data_out,
  output reg flash_data_oe_out,
  input wire [15:0] flash_data_in,
  output reg boot_guard_pin_out,
  output reg accel_high_voltage_out
);
  localparam integer HOLD_N = (`FGROC_T_RST_HOLD_NS + `FGROC_CLK_NS - 1) / `FGROC_CLK_NS;
  localparam integer WAKE_N = (`FGROC_T_RST_WAKE_NS + `FGROC_CLK_NS - 1) / `FGROC_CLK_NS;
  localparam integer WE_N = (`FGROC_T_WE_NS + `FGROC_CLK_NS - 1) / `FGROC_CLK_NS;
  localparam integer ACC_N = (`FGROC_T_ACC_NS + `FGROC_CLK_NS - 1) / `FGROC_CLK_NS + `FGROC_SYNC_CYCLES;
  localparam integer REC_N = (`FGROC_T_RECOV_NS + `FGROC_CLK_NS - 1) / `FGROC_CLK_NS;
  localparam [11:0] HOLD_CYC = HOLD_N[11:0];
  localparam [11:0] WAKE_CYC = WAKE_N[11:0];
  localparam [11:0] WE_CYC = WE_N[11:0];
  localparam [11:0] ACC_CYC = ACC_N[11:0];
  localparam [11:0] REC_CYC = REC_N[11:0];
  localparam [5:0] S_IDLE = 6'h01;
  localparam [5:0] S_RHOLD = 6'h02;
  localparam [5:0] S_RWAKE = 6'h04;
  localparam [5:0] S_SETUP = 6'h08;
  localparam [5:0] S_STROBE = 6'h10;
  localparam [5:0] S_RECOV = 6'h20;

  reg [5:0] state_q, state_d;
  reg [2:0] op_q;
  reg go_q;
  reg [1:0] step_q;
  reg [21:0] addr_q;
  reg [15:0] wdata_q;
  reg [15:0] rdata_q;
  reg [1:0] guard_q;
  reg query_q, otp_q, refused_q, ready_q;
  reg [15:0] din_meta_q, din_sync_q;
  reg load;
  reg [11:0] load_val;
  reg [21:0] seq_addr;
  reg [15:0] seq_data;
  reg seq_rd, seq_last, refuse;
  wire tdone;

  fgroc_timer u_timer (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .load_in(load),
    .count_in(load_val),
    .done_out(tdone)
  );

  // Flash data is asynchronous to the clock, so it passes two flops first.
  always @(posedge clock_in) begin
    din_meta_q <= flash_data_in;
    din_sync_q <= din_meta_q;
  end

  // Bus cycles of each operation, one step at a time.
  always @* begin
    seq_addr = addr_q;
    seq_data = wdata_q;
    seq_rd = 1'b0;
    seq_last = 1'b1;
    case (op_q)
      `FGROC_OP_READ: seq_rd = 1'b1;
      `FGROC_OP_RESET_CMD: seq_data = `FGROC_CMD_RESET;
      `FGROC_OP_QUERY: begin
        seq_addr = `FGROC_ADDR_QUERY;
        seq_data = `FGROC_CMD_QUERY;
      end
      `FGROC_OP_ACCEL_PROG: begin
        seq_last = (step_q == 2'h1);
        if (step_q == 2'h0) begin
          seq_data = `FGROC_CMD_ACCEL;
        end
      end
      `FGROC_OP_OTP_ENTER, `FGROC_OP_OTP_EXIT: begin
        seq_last = (op_q == `FGROC_OP_OTP_ENTER) ? (step_q == 2'h2) : (step_q == 2'h3);
        case (step_q)
          2'h0: begin
            seq_addr = `FGROC_ADDR_UNLOCK1;
            seq_data = `FGROC_CMD_UNLOCK1;
          end
          2'h1: begin
            seq_addr = `FGROC_ADDR_UNLOCK2;
            seq_data = `FGROC_CMD_UNLOCK2;
          end
          2'h2: begin
            seq_addr = `FGROC_ADDR_UNLOCK1;
            seq_data = (op_q == `FGROC_OP_OTP_ENTER) ? `FGROC_CMD_OTP_ENTER : `FGROC_CMD_OTP_EXIT;
          end
          default: seq_data = `FGROC_CMD_OTP_EXIT2;
        endcase
      end
      default: seq_last = 1'b1;
    endcase
  end

  // Acceleration needs the high-voltage guard and is barred while the one-time region is mapped.
  always @* begin
    refuse = (op_q == `FGROC_OP_ACCEL_PROG) && (otp_q || guard_q != `FGROC_GUARD_ACCEL);
  end

  always @* begin
    state_d = state_q;
    load = 1'b0;
    load_val = REC_CYC;
    case (state_q)
      S_IDLE: begin
        if (go_q && op_q == `FGROC_OP_HW_RESET) begin
          state_d = S_RHOLD;
          load = 1'b1;
          load_val = HOLD_CYC;
        end else if (go_q && !refuse) begin
          state_d = S_SETUP;
        end
      end
      S_RHOLD: begin
        if (tdone && !load) begin
          state_d = S_RWAKE;
          load = 1'b1;
          load_val = WAKE_CYC;
        end
      end
      S_RWAKE: begin
        if (tdone) begin
          state_d = S_IDLE;
        end
      end
      S_SETUP: begin
        state_d = S_STROBE;
        load = 1'b1;
        load_val = seq_rd ? ACC_CYC : WE_CYC;
      end
      S_STROBE: begin
        if (tdone) begin
          state_d = S_RECOV;
          load = 1'b1;
          load_val = REC_CYC;
        end
      end
      S_RECOV: begin
        if (tdone) begin
          state_d = seq_last ? S_IDLE : S_SETUP;
        end
      end
      default: state_d = S_IDLE;
    endcase
  end

  always @(posedge clock_in) begin
    if (rst_in) begin
      // Reset queues a flash reset, so the hold timer is loaded from idle.
      state_q <= S_IDLE;
      op_q <= `FGROC_OP_HW_RESET;
      go_q <= 1'b1;
      step_q <= 2'h0;
      addr_q <= 22'h000000;
      wdata_q <= 16'h0000;
      rdata_q <= 16'h0000;
      guard_q <= `FGROC_GUARD_LOW;
      query_q <= 1'b0;
      otp_q <= 1'b0;
      refused_q <= 1'b0;
      ready_q <= 1'b0;
      reg_rdata_out <= 32'h00000000;
      flash_ce_n_out <= 1'b1;
      flash_oe_n_out <= 1'b1;
      flash_we_n_out <= 1'b1;
      flash_reset_n_out <= 1'b0;
      flash_addr_out <= 22'h000000;
      flash_data_out <= 16'h0000;
      flash_data_oe_out <= 1'b0;
      boot_guard_pin_out <= 1'b0;
      accel_high_voltage_out <= 1'b0;
    end else begin
      state_q <= state_d;
      if (state_q == S_IDLE && go_q) begin
        go_q <= 1'b0;
        step_q <= 2'h0;
        refused_q <= refuse;
        if (op_q == `FGROC_OP_HW_RESET) begin
          ready_q <= 1'b0;
          query_q <= 1'b0;
          otp_q <= 1'b0;
        end
      end
      if (state_q == S_RWAKE && tdone) begin
        ready_q <= 1'b1;
      end
      if (state_q == S_STROBE && tdone && seq_rd) begin
        rdata_q <= query_q ? {8'h00, din_sync_q[7:0]} : din_sync_q;
      end
      if (state_q == S_RECOV && tdone) begin
        if (seq_last) begin
          if (op_q == `FGROC_OP_QUERY) begin
            query_q <= 1'b1;
          end
          if (op_q == `FGROC_OP_RESET_CMD) begin
            query_q <= 1'b0;
          end
          if (op_q == `FGROC_OP_OTP_ENTER) begin
            otp_q <= 1'b1;
          end
          if (op_q == `FGROC_OP_OTP_EXIT) begin
            otp_q <= 1'b0;
          end
        end else begin
          step_q <= step_q + 2'h1;
        end
      end
      if (reg_write_in) begin
        case (reg_addr_in)
          `FGROC_REG_CTRL: begin
            if (state_q == S_IDLE && !go_q) begin
              op_q <= reg_wdata_in[2:0];
              go_q <= 1'b1;
            end
          end
          `FGROC_REG_ADDR: addr_q <= reg_wdata_in[21:0];
          `FGROC_REG_WDATA: wdata_q <= reg_wdata_in[15:0];
          `FGROC_REG_GUARD: begin
            if (!(otp_q && reg_wdata_in[1:0] == `FGROC_GUARD_ACCEL) && reg_wdata_in[1:0] != 2'h3) begin
              guard_q <= reg_wdata_in[1:0];
            end
          end
          default: ;
        endcase
      end
      if (reg_read_in) begin
        case (reg_addr_in)
          `FGROC_REG_CTRL: reg_rdata_out <= {29'h00000000, op_q};
          `FGROC_REG_ADDR: reg_rdata_out <= {10'h000, addr_q};
          `FGROC_REG_WDATA: reg_rdata_out <= {16'h0000, wdata_q};
          `FGROC_REG_RDATA: reg_rdata_out <= {16'h0000, rdata_q};
          `FGROC_REG_STATUS: reg_rdata_out <= {27'h0000000, ready_q, refused_q, otp_q, query_q,
                                               (state_q != S_IDLE) | go_q};
          `FGROC_REG_GUARD: reg_rdata_out <= {30'h00000000, guard_q};
          default: reg_rdata_out <= 32'h00000000;
        endcase
      end else begin
        reg_rdata_out <= 32'h00000000;
      end
      // Pin levels follow the next state so that every pin comes from a flop.
      flash_reset_n_out <= (state_d != S_RHOLD);
      // Select and data outlast the write strobe by one cycle, and the strobe falls two cycles after select and at least one after the address.
      flash_ce_n_out <= !(state_d == S_SETUP || state_d == S_STROBE || state_q == S_STROBE);
      flash_we_n_out <= !(state_d == S_STROBE && state_q == S_STROBE && !seq_rd);
      flash_oe_n_out <= !(state_d == S_STROBE && seq_rd);
      flash_data_oe_out <= (state_d == S_SETUP || state_d == S_STROBE || state_q == S_STROBE) && !seq_rd;
      flash_addr_out <= seq_addr;
      flash_data_out <= seq_data;
      boot_guard_pin_out <= (guard_q != `FGROC_GUARD_LOW);
      accel_high_voltage_out <= (guard_q == `FGROC_GUARD_ACCEL) && !otp_q;
    end
  end
endmodule // fgroc_ctrl

// >>> inc/fgroc_map.vh
// Constants for the boot-guard, reset and one-time-region flash host controller.
// Assumes a 125 MHz clock_in and a word-wide asynchronous NOR flash on the far side.
`ifndef FGROC_MAP_VH
`define FGROC_MAP_VH
`define FGROC_CLK_NS 8
`define FGROC_T_RST_HOLD_NS 500
`define FGROC_T_RST_WAKE_NS 200
`define FGROC_T_WE_NS 48
`define FGROC_T_ACC_NS 96
`define FGROC_T_RECOV_NS 24
`define FGROC_SYNC_CYCLES 2
`define FGROC_REG_CTRL 8'h00
`define FGROC_REG_ADDR 8'h04
`define FGROC_REG_WDATA 8'h08
`define FGROC_REG_RDATA 8'h0C
`define FGROC_REG_STATUS 8'h10
`define FGROC_REG_GUARD 8'h14
`define FGROC_OP_HW_RESET 3'h0
`define FGROC_OP_READ 3'h1
`define FGROC_OP_WRITE 3'h2
`define FGROC_OP_RESET_CMD 3'h3
`define FGROC_OP_QUERY 3'h4
`define FGROC_OP_ACCEL_PROG 3'h5
`define FGROC_OP_OTP_ENTER 3'h6
`define FGROC_OP_OTP_EXIT 3'h7
`define FGROC_GUARD_LOW 2'h0
`define FGROC_GUARD_HIGH 2'h1
`define FGROC_GUARD_ACCEL 2'h2
`define FGROC_CMD_RESET 16'h00F0
`define FGROC_CMD_QUERY 16'h0098
`define FGROC_ADDR_QUERY 22'h000055
`define FGROC_CMD_ACCEL 16'h00A0
`define FGROC_ADDR_UNLOCK1 22'h000555
`define FGROC_ADDR_UNLOCK2 22'h0002AA
`define FGROC_CMD_UNLOCK1 16'h00AA
`define FGROC_CMD_UNLOCK2 16'h0055
`define FGROC_CMD_OTP_ENTER 16'h0088
`define FGROC_CMD_OTP_EXIT 16'h0090
`define FGROC_CMD_OTP_EXIT2 16'h0000
`define FGROC_OTP_LAST_ADDR 22'h0000FF
`endif

// >>> design/fgroc_timer.v
// Down-counting delay timer used to pace the flash bus phases.
// Assumes load_in is a one-cycle request in the clock_in domain.
`timescale 1ns/10ps
module fgroc_timer (
  input wire clock_in,
  input wire rst_in,
  input wire load_in,
  input wire [11:0] count_in,
  output reg done_out
);
  reg [11:0] count_q;

  always @(posedge clock_in) begin
    if (rst_in) begin
      count_q <= 12'h000;
      done_out <= 1'b0;
    end else if (load_in) begin
      count_q <= count_in;
      done_out <= 1'b0;
    end else begin
      if (count_q != 12'h000) begin
        count_q <= count_q - 12'h001;
      end
      done_out <= (count_q <= 12'h001);
    end
  end
endmodule // fgroc_timer

// >>> testbench/fgroc_ctrl_assertions.sv
// Pin checks for the flash host controller.
// Assumes it is bound to fgroc_ctrl, one clock domain.
`timescale 1ns/10ps
module fgroc_chk (
  input logic clock_in,
  input logic rst_in,
  input logic flash_ce_n_out,
  input logic flash_oe_n_out,
  input logic flash_we_n_out,
  input logic flash_reset_n_out,
  input logic [21:0] flash_addr_out,
  input logic [15:0] flash_data_out,
  input logic flash_data_oe_out,
  input logic accel_high_voltage_out
);
  logic [6:0] low_q;
  logic [4:0] wake_q;
  default clocking @(posedge clock_in); endclocking
  default disable iff (rst_in);
  always @(posedge clock_in) begin
    low_q <= (rst_in || flash_reset_n_out) ? 7'h00 : low_q + {6'h00, low_q != 7'h7F};
    wake_q <= (rst_in || !flash_reset_n_out) ? 5'h00 : wake_q + {4'h0, wake_q != 5'h1F};
  end
  chk_reset_hold: assert property ($rose(flash_reset_n_out) |-> low_q >= 7'h3F)
    else $error("flash reset pulse too short");
  chk_wake_wait: assert property (flash_reset_n_out && wake_q < 5'h19 |-> flash_oe_n_out)
    else $error("read too soon after reset");
  chk_rst_quiet: assert property (disable iff (1'b0) rst_in |=> !flash_reset_n_out
    && flash_we_n_out && !accel_high_voltage_out)
    else $error("flash not held in reset");
  chk_write_qual: assert property (!flash_we_n_out |-> !flash_ce_n_out && flash_oe_n_out)
    else $error("write strobe without select");
  chk_no_fight: assert property (!flash_oe_n_out || !flash_reset_n_out |-> !flash_data_oe_out)
    else $error("host drives data bus");
  chk_we_width: assert property ($fell(flash_we_n_out) |-> !flash_we_n_out [*6])
    else $error("write strobe too short");
  chk_bus_steady: assert property (!flash_we_n_out && !$past(flash_we_n_out) |->
    $stable(flash_addr_out) && $stable(flash_data_out))
    else $error("address or data moved in write");
  chk_drive_write: assert property (!flash_we_n_out |-> flash_data_oe_out)
    else $error("write without data drive");
endmodule // fgroc_chk
bind fgroc_ctrl fgroc_chk u_chk (.*);

// >>> testbench/fgroc_flash_model.sv
// Behavioural flash device on the far side of the controller.
// Assumes pins from fgroc_ctrl; reads answer at once.
`timescale 1ns/10ps
module fgroc_flash_model (
  input logic ce_n_in,
  input logic oe_n_in,
  input logic we_n_in,
  input logic reset_n_in,
  input logic [21:0] addr_in,
  input logic [15:0] data_in,
  input logic guard_in,
  input logic hv_in,
  output logic [15:0] data_out
);
  localparam logic factory_lock_bit = 1'b0;
  localparam logic customer_lock_bit = 1'b0;
  logic [15:0] mem [0:15];
  logic [15:0] last_q = 16'h0000;
  logic query_q = 1'b0;
  logic otp_q = 1'b0;
  logic arm_q = 1'b0;
  wire [3:0] idx = {addr_in[21], addr_in[2:0]};
  wire boot = addr_in[21:13] == 9'h000 || addr_in[21:13] == 9'h1FF;
  initial begin
    for (int i = 0; i < 16; i++) begin
      mem[i] = 16'hFFFF;
    end
  end
  always @(negedge reset_n_in or posedge we_n_in) begin
    if (!reset_n_in) begin
      query_q <= 1'b0;
      otp_q <= 1'b0;
      arm_q <= 1'b0;
    end else if (!ce_n_in && oe_n_in) begin
      if (arm_q && !otp_q && (guard_in || hv_in || !boot)) begin
        mem[idx] <= data_in;
      end
      arm_q <= data_in == 16'h00A0 && !arm_q;
      if (data_in == 16'h0098 && addr_in == 22'h000055) begin
        query_q <= 1'b1;
      end
      // Programs finish at the strobe, so a reset command never meets a running one.
      if (data_in == 16'h00F0) begin
        query_q <= 1'b0;
      end
      // Suspend is not modelled, so lock programming never overlaps one.
      if (data_in == 16'h0088) begin
        otp_q <= 1'b1;
      end
      if (data_in == 16'h0090) begin
        otp_q <= 1'b0;
      end
    end
  end
  always @* begin
    if (reset_n_in && !ce_n_in && !oe_n_in) begin
      if (query_q) begin
        data_out = {8'h00, addr_in[7:0] ^ 8'h3C};
      end else if (otp_q && addr_in <= 22'h0000FF) begin
        data_out = {8'h00, factory_lock_bit, customer_lock_bit, addr_in[5:0]};
      end else begin
        data_out = mem[idx];
      end
      last_q = data_out;
    end else begin
      data_out = ~last_q;
    end
  end
endmodule // fgroc_flash_model

// >>> testbench/flash_guard_reset_otp_ctrl_bench.sv
// Self-checking bench for the flash host controller.
// Assumes the behavioural flash model on the pins.
`timescale 1ns/10ps
`include "fgroc_map.vh"
module flash_guard_reset_otp_ctrl_bench;
  logic clock_in = 1'b0;
  logic rst_in = 1'b1;
  logic [7:0] ra = 8'h00;
  logic [31:0] wd = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic chk = 1'b0;
  logic rs = 1'b0;
  logic [31:0] rdata;
  logic ce_n, oe_n, we_n, rst_n, doe, guard, hv;
  logic [21:0] fa;
  logic [15:0] fdo, fdi, pd;
  logic [71:0] q[$];
  int n_errors = 0;
  int check_count = 0;
  int seed = 75;
  int cyc = 0;
  always #4 clock_in = ~clock_in;
  fgroc_ctrl dut (.clock_in(clock_in), .rst_in(rst_in), .reg_addr_in(ra), .reg_wdata_in(wd),
    .reg_write_in(wr), .reg_read_in(rd), .reg_rdata_out(rdata), .flash_ce_n_out(ce_n),
    .flash_oe_n_out(oe_n), .flash_we_n_out(we_n), .flash_reset_n_out(rst_n), .flash_addr_out(fa),
    .flash_data_out(fdo), .flash_data_oe_out(doe), .flash_data_in(fdi), .boot_guard_pin_out(guard),
    .accel_high_voltage_out(hv));
  fgroc_flash_model mdl (.ce_n_in(ce_n), .oe_n_in(oe_n), .we_n_in(we_n), .reset_n_in(rst_n),
    .addr_in(fa), .data_in(fdo), .guard_in(guard), .hv_in(hv), .data_out(fdi));
  task automatic stop_test;
    if (n_errors == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic cmp(input logic [7:0] a, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch reg %h expected %h seen %h", a, e, g);
    end
  endtask
  // Kind 0 writes, 1 reads and notes the expected value, 2 polls.
  task automatic bus(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m,
    input logic [1:0] k);
    @(posedge clock_in);
    ra <= a;
    wd <= d;
    wr <= k == 2'h0;
    rd <= k != 2'h0;
    chk <= k == 2'h1;
    if (k == 2'h1) begin
      q.push_back({a, d & m, m});
    end
    @(posedge clock_in);
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task automatic idle;
    int k;
    k = 0;
    do begin
      bus(`FGROC_REG_STATUS, 32'h0, 32'h0, 2'h2);
      @(posedge clock_in);
      k++;
    end while ((rdata[0] !== 1'b0 || rdata[4] !== 1'b1) && k < 300);
    if (k == 300) begin
      n_errors++;
      $display("mismatch status expected 10 seen %h", rdata[4:0]);
    end
  endtask
  task automatic op(input logic [2:0] c);
    bus(`FGROC_REG_CTRL, {29'h0, c}, 32'h0, 2'h0);
    idle();
  endtask
  task automatic set(input logic [21:0] a, input logic [15:0] d);
    bus(`FGROC_REG_ADDR, {10'h0, a}, 32'h0, 2'h0);
    bus(`FGROC_REG_WDATA, {16'h0, d}, 32'h0, 2'h0);
  endtask
  task automatic prog(input logic [21:0] a, input logic [15:0] d);
    set(a, 16'h00A0);
    op(`FGROC_OP_WRITE);
    set(a, d);
    op(`FGROC_OP_WRITE);
  endtask
  task automatic look(input logic [21:0] a, input logic [15:0] e);
    set(a, 16'h0000);
    op(`FGROC_OP_READ);
    bus(`FGROC_REG_RDATA, {16'h0, e}, 32'hFFFF, 2'h1);
  endtask
  always @(posedge clock_in) begin
    if (rs) begin
      cmp(q[0][71:64], q[0][63:32], rdata & q[0][31:0]);
      void'(q.pop_front());
    end
    rs <= rd && chk;
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_errors++;
      $display("mismatch cycles expected below 30000 seen %0d", cyc);
      stop_test();
    end
  end
  initial begin
    repeat (3) @(posedge clock_in);
    rst_in <= 1'b0;
    idle();
    bus(`FGROC_REG_STATUS, 32'h10, 32'h1F, 2'h1);
    pd = 16'($random(seed));
    bus(`FGROC_REG_GUARD, 32'h0, 32'h0, 2'h0);
    prog(22'h000011, pd);
    look(22'h000011, 16'hFFFF);
    bus(`FGROC_REG_GUARD, 32'h1, 32'h0, 2'h0);
    prog(22'h3FFFF2, pd);
    look(22'h3FFFF2, pd);
    bus(`FGROC_REG_GUARD, 32'h2, 32'h0, 2'h0);
    pd = 16'($random(seed));
    set(22'h000013, pd);
    op(`FGROC_OP_ACCEL_PROG);
    look(22'h000013, pd);
    op(`FGROC_OP_QUERY);
    look(22'h000011, 16'h002D);
    op(`FGROC_OP_RESET_CMD);
    look(22'h000011, 16'hFFFF);
    op(`FGROC_OP_OTP_ENTER);
    op(`FGROC_OP_ACCEL_PROG);
    bus(`FGROC_REG_STATUS, 32'hC, 32'hC, 2'h1);
    bus(`FGROC_REG_GUARD, 32'h1, 32'h0, 2'h0);
    bus(`FGROC_REG_GUARD, 32'h2, 32'h0, 2'h0);
    bus(`FGROC_REG_GUARD, 32'h3, 32'h0, 2'h0);
    bus(`FGROC_REG_GUARD, 32'h1, 32'h3, 2'h1);
    op(`FGROC_OP_RESET_CMD);
    bus(`FGROC_REG_STATUS, 32'h4, 32'h4, 2'h1);
    op(`FGROC_OP_HW_RESET);
    bus(`FGROC_REG_STATUS, 32'h10, 32'h1F, 2'h1);
    op(`FGROC_OP_OTP_ENTER);
    look(22'h000011, 16'h0011);
    op(`FGROC_OP_OTP_EXIT);
    bus(`FGROC_REG_STATUS, 32'h0, 32'h4, 2'h1);
    bus(8'h3C, 32'h0, 32'hFFFFFFFF, 2'h1);
    stop_test();
  end
endmodule // flash_guard_reset_otp_ctrl_bench
